// ==== verilog/converter_clock_pll_control.v ====
`timescale 1ns/1ps
`include "clock_pll_consts.vh"
// How it works
// (R1) One sample clock drives every internal domain
// (R2) Host keeps reference within 25 to 3080 MHz
// (R3) Two-bit predivider field selects divide 1 to 4
// (R4) Host keeps detector input within 25-770 MHz
// (R5) Power bit zero enables the synthesizer
// (R6) Post-divider selects VCO, VCO/2, VCO/3 or VCO/4
// (R7) Rate is 8*N*ref/M/(post+1), N 2..50
// (R8) Falling edge of calibration bit starts calibration; here ignored while synthesizer powered down
// (R9) Read-only status bit shows PLL lock
// (R10) Output divider field selects divide 1 to 4
// (R11) Full-scale current follows its own code register
// (R12) Full-scale code resets to 19.531 mA setting
// (R13) Samples are two's complement, offset by half
// (R14) Shuffle enable bit selects shuffled or thermometer
// (R15) Shuffling remaps upper sources pseudorandomly per sample
// (R16) Duty cycle correction on when directly clocked
// (R17) Host polls lock before using synthesised clock
// (R18) Host reaches registers over serial interface

module converter_clock_pll_control #(
	parameter        SAMPLE_W   = 16,
	parameter        MSB_W      = 4,
	parameter [15:0] CAL_CYCLES = `VCO_CAL_CYCLES
) (
	input  wire                  clk,
	input  wire                  rst_b,
	input  wire [11:0]           reg_addr,
	input  wire [7:0]            reg_wdata,
	input  wire                  reg_wr,
	input  wire                  reg_rd,
	output reg  [7:0]            reg_rdata_q,
	input  wire [5:0]            feedback_ratio,
	input  wire                  pll_lock_detect,
	input  wire [SAMPLE_W-1:0]   converter_sample_code,
	input  wire                  sample_valid,
	output wire                  pll_enable,
	output wire                  sample_clock_from_pll,
	output wire                  duty_cycle_correction_en,
	output wire [2:0]            predivider_ratio,
	output wire [2:0]            post_divider_ratio,
	output wire [2:0]            clock_output_ratio,
	output wire [8:0]            vco_multiplier,
	output wire                  feedback_ratio_valid,
	output wire [7:0]            full_scale_current_code,
	output reg                   vco_cal_start_q,
	output wire                  vco_cal_busy,
	output wire                  pll_locked,
	output wire                  clock_output_tick,
	output reg  [SAMPLE_W-1:0]   positive_branch_code_q,
	output reg  [SAMPLE_W-1:0]   negative_branch_code_q,
	output wire [(1<<MSB_W)-2:0] msb_source_select
);

	// Calibration state codes
	localparam [1:0] ST_IDLE = 2'b00;   // No calibration since reset or power-down
	localparam [1:0] ST_CAL  = 2'b01;   // VCO band search running
	localparam [1:0] ST_WAIT = 2'b10;   // Waiting for loop lock
	localparam [1:0] ST_LOCK = 2'b11;   // Loop locked

	// Half-range offset for the sample code
	localparam [SAMPLE_W-1:0] HALF_RANGE = {1'b1, {(SAMPLE_W-1){1'b0}}};

	// Configuration fields held from register writes
	reg  [7:0]  fsc_code_q;      // Full-scale current code
	reg  [1:0]  post_div_q;      // Post-divider field
	reg         pll_pdn_q;       // Synthesizer power-down
	reg         shuffle_en_q;    // Upper-bit shuffle enable
	reg         cal_bit_q;       // Calibration trigger bit
	reg  [1:0]  predivider_q;    // Reference predivider field
	reg  [1:0]  clkout_div_q;    // Output clock divider field
	reg  [1:0]  state_q;         // Calibration state
	reg  [1:0]  state_d;         // Next calibration state
	reg  [15:0] cal_cnt_q;       // Calibration cycle count
	reg  [15:0] cal_cnt_d;       // Next calibration count
	reg  [7:0]  rdata_d;         // Read mux result
	wire        cal_trigger;     // Falling edge of the trigger bit
	wire [SAMPLE_W-1:0] offset_code;   // Code shifted to unsigned

	// Field value plus one gives the divide ratio
	function [2:0] field_ratio;
		input [1:0] field;
		begin
			field_ratio = {1'b0, field} + 3'h1;
		end
	endfunction

	// Address match helper
	function hit;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// Register writes from the serial interface decoder
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Synthesizer starts off, so the input pins clock the device
			fsc_code_q   <= `RST_FULL_SCALE_CODE; // R12
			post_div_q   <= `RST_RATIO_FIELD;
			pll_pdn_q    <= `RST_PLL_POWER_DOWN;
			shuffle_en_q <= 1'b0;
			cal_bit_q    <= 1'b0;
			predivider_q <= `RST_RATIO_FIELD;
			clkout_div_q <= `RST_RATIO_FIELD;
		end else if (reg_wr) begin // R18
			// Each offset owns its fields; other bits are dropped
			if (hit(reg_addr, `OFS_FULL_SCALE_CURRENT_CODE)) begin
				fsc_code_q <= reg_wdata; // R11
			end
			if (hit(reg_addr, `OFS_PLL_POST_DIVIDER)) begin
				post_div_q <= reg_wdata[`FLD_RATIO_HI:`FLD_RATIO_LO]; // R6
			end
			if (hit(reg_addr, `OFS_PLL_POWER_CONTROL)) begin
				pll_pdn_q <= reg_wdata[`BIT_PLL_POWER_DOWN]; // R5
			end
			if (hit(reg_addr, `OFS_SHUFFLE_CONTROL)) begin
				shuffle_en_q <= reg_wdata[`BIT_SHUFFLE_ENABLE]; // R14
			end
			if (hit(reg_addr, `OFS_VCO_CALIBRATION_CONTROL)) begin
				cal_bit_q <= reg_wdata[`BIT_VCO_CAL_TRIGGER];
			end
			if (hit(reg_addr, `OFS_REFERENCE_PREDIVIDER)) begin
				predivider_q <= reg_wdata[`FLD_RATIO_HI:`FLD_RATIO_LO]; // R3
			end
			if (hit(reg_addr, `OFS_CLOCK_OUTPUT_DIVIDER)) begin
				clkout_div_q <= reg_wdata[`FLD_CLKOUT_HI:`FLD_CLKOUT_LO]; // R10
			end
		end
	end

	// Calibration starts only on a one-to-zero write of the bit
	// Rewriting zero over zero, or one over one, starts nothing;
	// the bit itself keeps the last written value
	assign cal_trigger = reg_wr && hit(reg_addr, `OFS_VCO_CALIBRATION_CONTROL)
		&& cal_bit_q && !reg_wdata[`BIT_VCO_CAL_TRIGGER]; // R8

	// Clock source selection and ratio outputs
	// Powered-down synthesizer leaves the direct input as sample clock
	assign pll_enable               = !pll_pdn_q; // R5
	assign sample_clock_from_pll    = !pll_pdn_q; // R1
	assign duty_cycle_correction_en = pll_pdn_q; // R16
	assign predivider_ratio         = field_ratio(predivider_q); // R3
	assign post_divider_ratio       = field_ratio(post_div_q); // R6
	assign clock_output_ratio       = field_ratio(clkout_div_q); // R10
	// Multiply by eight is a three-bit shift of N
	assign vco_multiplier           = {feedback_ratio, 3'b000}; // R7
	assign feedback_ratio_valid     = (feedback_ratio >= `FEEDBACK_MIN)
		&& (feedback_ratio <= `FEEDBACK_MAX); // R7
	assign full_scale_current_code  = fsc_code_q; // R11

	// Calibration sequencer next state
	// Lock loss is not latched; software polls the status bit instead
	always @* begin
		state_d   = state_q;
		cal_cnt_d = cal_cnt_q;
		case (state_q)
			ST_IDLE: begin
				// Wait for a trigger with the synthesizer powered
				if (cal_trigger && !pll_pdn_q) begin
					state_d   = ST_CAL;
					cal_cnt_d = 16'h0000;
				end
			end
			ST_CAL: begin
				// Band search runs a fixed number of cycles
				if (cal_cnt_q >= CAL_CYCLES - 16'h0001) begin
					state_d = ST_WAIT;
				end else begin
					cal_cnt_d = cal_cnt_q + 16'h0001;
				end
			end
			ST_WAIT: begin
				// Hold here until the detector reports lock
				if (pll_lock_detect) begin
					state_d = ST_LOCK;
				end
			end
			ST_LOCK: begin
				// Lost lock drops back to waiting
				if (!pll_lock_detect) begin
					state_d = ST_WAIT;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
		// A new trigger restarts the search from any state
		if (cal_trigger && !pll_pdn_q && state_q != ST_IDLE) begin
			state_d   = ST_CAL;
			cal_cnt_d = 16'h0000;
		end
		// Powering the synthesizer down abandons calibration
		if (pll_pdn_q) begin
			state_d   = ST_IDLE;
			cal_cnt_d = 16'h0000;
		end
	end

	// Calibration sequencer registers
	// Start pulse is a registered copy of the accepted trigger
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q         <= ST_IDLE;
			cal_cnt_q       <= 16'h0000;
			vco_cal_start_q <= 1'b0;
		end else begin
			state_q         <= state_d;
			cal_cnt_q       <= cal_cnt_d;
			vco_cal_start_q <= cal_trigger && !pll_pdn_q; // R8
		end
	end

	// Status decodes from the sequencer state
	assign vco_cal_busy = (state_q == ST_CAL); // R8
	assign pll_locked   = (state_q == ST_LOCK) && pll_lock_detect; // R9

	// Read mux; unmapped offsets and reserved bits read zero
	// Reads have no side effects, so polling lock status is safe
	always @* begin
		rdata_d = 8'h00;
		case (reg_addr)
			`OFS_FULL_SCALE_CURRENT_CODE: begin
				rdata_d = fsc_code_q;
			end
			`OFS_PLL_POST_DIVIDER: begin
				rdata_d[`FLD_RATIO_HI:`FLD_RATIO_LO] = post_div_q;
			end
			`OFS_PLL_POWER_CONTROL: begin
				rdata_d[`BIT_PLL_POWER_DOWN] = pll_pdn_q;
			end
			`OFS_SHUFFLE_CONTROL: begin
				rdata_d[`BIT_SHUFFLE_ENABLE] = shuffle_en_q;
			end
			`OFS_VCO_CALIBRATION_CONTROL: begin
				rdata_d[`BIT_VCO_CAL_TRIGGER] = cal_bit_q;
			end
			`OFS_REFERENCE_PREDIVIDER: begin
				rdata_d[`FLD_RATIO_HI:`FLD_RATIO_LO] = predivider_q;
			end
			`OFS_CLOCK_OUTPUT_DIVIDER: begin
				rdata_d[`FLD_CLKOUT_HI:`FLD_CLKOUT_LO] = clkout_div_q;
			end
			`OFS_PLL_LOCK_STATUS: begin
				rdata_d[`BIT_PLL_LOCKED] = pll_locked; // R9
			end
			default: begin
				rdata_d = 8'h00;
			end
		endcase
	end

	// Read data register, updated on each read strobe
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata_q <= rdata_d;
		end
	end

	// Two's complement to offset binary: invert the sign bit
	// Offset binary lets the current sources take the code directly
	assign offset_code = converter_sample_code ^ HALF_RANGE; // R13

	// Branch codes for the positive and negative current outputs
	// Both branches load together so the pair never shows mixed samples
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			positive_branch_code_q <= HALF_RANGE;
			negative_branch_code_q <= ~HALF_RANGE;
		end else if (sample_valid) begin
			positive_branch_code_q <= offset_code; // R13
			negative_branch_code_q <= ~offset_code; // R13
		end
	end

	// Divided clock for a companion converter
	// Free-running, so the companion always sees a clock after reset
	output_clock_divider u_clkout (
		.clk         (clk),
		.rst_b       (rst_b),
		.ratio_field (clkout_div_q),
		.tick_q      (clock_output_tick)
	);

	// Upper-bit source selection, shuffled or thermometer
	// Top MSB_W bits of the offset code say how many sources are on
	msb_shuffler #(
		.MSB_W (MSB_W)
	) u_shuffle (
		.clk          (clk),
		.rst_b        (rst_b),
		.shuffle_en   (shuffle_en_q),
		.advance      (sample_valid),
		.msb_value    (offset_code[SAMPLE_W-1:SAMPLE_W-MSB_W]),
		.source_sel_q (msb_source_select)
	);

endmodule

// ==== verilog/clock_pll_consts.vh ====
`ifndef CLOCK_PLL_CONSTS_VH
`define CLOCK_PLL_CONSTS_VH

// Register offsets (12-bit register address space)
`define OFS_FULL_SCALE_CURRENT_CODE 12'h05A
`define OFS_PLL_POST_DIVIDER        12'h094
`define OFS_PLL_POWER_CONTROL       12'h095
`define OFS_SHUFFLE_CONTROL         12'h151
`define OFS_VCO_CALIBRATION_CONTROL 12'h792
`define OFS_REFERENCE_PREDIVIDER    12'h793
`define OFS_CLOCK_OUTPUT_DIVIDER    12'h799
`define OFS_PLL_LOCK_STATUS         12'h7B5

// Field positions
`define BIT_PLL_POWER_DOWN   0
`define BIT_VCO_CAL_TRIGGER  1
`define BIT_SHUFFLE_ENABLE   4
`define BIT_PLL_LOCKED       0
`define FLD_RATIO_LO         0
`define FLD_RATIO_HI         1
`define FLD_CLKOUT_LO        6
`define FLD_CLKOUT_HI        7

// Reset values
`define RST_FULL_SCALE_CODE  8'h28
`define RST_PLL_POWER_DOWN   1'h1
`define RST_RATIO_FIELD      2'h0

// Feedback ratio limits
`define FEEDBACK_MIN         6'h02
`define FEEDBACK_MAX         6'h32

// Shuffle pseudorandom generator
`define LFSR_SEED            16'hACE1
`define LFSR_TAPS            16'hB400

// Calibration time in sample clock cycles (no figure given)
`define VCO_CAL_CYCLES       16'h0100

`endif

// ==== verilog/output_clock_divider.v ====
`timescale 1ns/1ps
`include "clock_pll_consts.vh"

module output_clock_divider (
	input  wire       clk,
	input  wire       rst_b,
	input  wire [1:0] ratio_field,
	output reg        tick_q
);

	reg [1:0] count_q;   // Cycles since last tick

	// Tick once every ratio_field+1 sample clock cycles
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 2'h0;
			tick_q  <= 1'b0;
		end else if (count_q >= ratio_field) begin
			// Period complete, also covers a ratio lowered mid-period
			count_q <= 2'h0;
			tick_q  <= 1'b1;
		end else begin
			count_q <= count_q + 2'h1;
			tick_q  <= 1'b0;
		end
	end

endmodule

// ==== verilog/msb_shuffler.v ====
`timescale 1ns/1ps
`include "clock_pll_consts.vh"

module msb_shuffler #(
	parameter MSB_W = 4
) (
	input  wire                      clk,
	input  wire                      rst_b,
	input  wire                      shuffle_en,
	input  wire                      advance,
	input  wire [MSB_W-1:0]          msb_value,
	output reg  [(1<<MSB_W)-2:0]     source_sel_q
);

	localparam POOL = (1 << MSB_W) - 1;   // Number of upper-bit sources

	reg  [15:0]         lfsr_q;    // Pseudorandom state
	wire [POOL-1:0]     thermo;    // Plain thermometer code
	wire [MSB_W-1:0]    rot;       // Rotation amount
	wire [2*POOL-1:0]   doubled;   // Thermometer shifted around the pool

	// Thermometer: source i is on when the value exceeds i
	genvar i;
	generate
		for (i = 0; i < POOL; i = i + 1) begin : g_thermo
			localparam [MSB_W-1:0] IDX = i;
			assign thermo[i] = (msb_value > IDX);
		end
	endgenerate

	assign rot     = shuffle_en ? lfsr_q[MSB_W-1:0] : {MSB_W{1'b0}};
	assign doubled = {thermo, thermo} >> rot;

	// Galois LFSR steps once per sample
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lfsr_q <= `LFSR_SEED;
		end else if (advance) begin
			lfsr_q <= (lfsr_q >> 1) ^ (lfsr_q[0] ? `LFSR_TAPS : 16'h0000);
		end
	end

	// Register the source selection on the same edge as the branch codes
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			source_sel_q <= {POOL{1'b0}};
		end else if (advance) begin
			source_sel_q <= doubled[POOL-1:0]; // R15
		end
	end

endmodule

// ==== test/clock_pll_sva.sv ====
`timescale 1ns/1ps
module clock_pll_sva #(
	parameter SAMPLE_W = 16,
	parameter MSB_W    = 4
) (
	input wire                  clk,
	input wire                  rst_b,
	input wire [11:0]           reg_addr,
	input wire [7:0]            reg_wdata,
	input wire                  reg_wr,
	input wire                  reg_rd,
	input wire [7:0]            reg_rdata_q,
	input wire [5:0]            feedback_ratio,
	input wire [SAMPLE_W-1:0]   converter_sample_code,
	input wire                  sample_valid,
	input wire                  pll_enable,
	input wire [2:0]            predivider_ratio,
	input wire [8:0]            vco_multiplier,
	input wire                  feedback_ratio_valid,
	input wire [7:0]            full_scale_current_code,
	input wire                  vco_cal_start_q,
	input wire                  vco_cal_busy,
	input wire                  pll_locked,
	input wire [SAMPLE_W-1:0]   positive_branch_code_q,
	input wire [SAMPLE_W-1:0]   negative_branch_code_q,
	input wire [(1<<MSB_W)-2:0] msb_source_select
);
	localparam [SAMPLE_W-1:0] HALF = 1 << (SAMPLE_W - 1); // Half code range
	logic             cal_fall_q; // Trigger bit written low last edge
	logic [MSB_W-1:0] top_q;      // Offset upper bits of last input

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Capture trigger writes and upper offset bits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_fall_q <= 1'b0;
			top_q <= '0;
		end else begin
			cal_fall_q <= reg_wr && reg_addr == 12'h792 && !reg_wdata[1];
			top_q <= converter_sample_code[SAMPLE_W-1 -: MSB_W] ^ HALF[SAMPLE_W-1 -: MSB_W];
		end
	end

	property p_power; reg_wr && reg_addr == 12'h095 |=> pll_enable != $past(reg_wdata[0]); endproperty
	a_power: assert property (p_power) else $error("pll enable wrong");
	property p_pre; reg_wr && reg_addr == 12'h793 |=> predivider_ratio == $past(reg_wdata[1:0]) + 3'd1;
	endproperty
	a_pre: assert property (p_pre) else $error("predivider wrong");
	property p_fsc; reg_wr && reg_addr == 12'h05A |=> full_scale_current_code == $past(reg_wdata);
	endproperty
	a_fsc: assert property (p_fsc) else $error("full scale code wrong");
	property p_mult; vco_multiplier == {feedback_ratio, 3'h0}
		&& feedback_ratio_valid == (feedback_ratio >= 6'h02 && feedback_ratio <= 6'h32); endproperty
	a_mult: assert property (p_mult) else $error("feedback figures wrong");
	property p_cal; vco_cal_start_q |-> cal_fall_q && vco_cal_busy ##[1:1000] !vco_cal_busy;
	endproperty
	a_cal: assert property (p_cal) else $error("calibration start wrong");
	property p_lock; reg_rd && reg_addr == 12'h7B5 |=> reg_rdata_q == {7'h00, $past(pll_locked)};
	endproperty
	a_lock: assert property (p_lock) else $error("lock status wrong");
	property p_branch; sample_valid |=> positive_branch_code_q == ($past(converter_sample_code) ^ HALF)
		&& negative_branch_code_q == ~positive_branch_code_q; endproperty
	a_branch: assert property (p_branch) else $error("branch codes wrong");
	property p_pool; sample_valid |=> $countones(msb_source_select) == top_q; endproperty
	a_pool: assert property (p_pool) else $error("active source count wrong");

	c_cal: cover property (vco_cal_start_q);
	c_lock: cover property (pll_locked);
	c_burst: cover property (sample_valid ##1 sample_valid);
endmodule

bind converter_clock_pll_control clock_pll_sva #(.SAMPLE_W(SAMPLE_W), .MSB_W(MSB_W)) chk_u (
	.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .feedback_ratio(feedback_ratio),
	.converter_sample_code(converter_sample_code), .sample_valid(sample_valid),
	.pll_enable(pll_enable), .predivider_ratio(predivider_ratio), .vco_multiplier(vco_multiplier),
	.feedback_ratio_valid(feedback_ratio_valid), .full_scale_current_code(full_scale_current_code),
	.vco_cal_start_q(vco_cal_start_q), .vco_cal_busy(vco_cal_busy), .pll_locked(pll_locked),
	.positive_branch_code_q(positive_branch_code_q), .negative_branch_code_q(negative_branch_code_q),
	.msb_source_select(msb_source_select));

// ==== test/lock_detect_model.sv ====
`timescale 1ns/1ps
module lock_detect_model #(
	parameter LOCK_DELAY = 3
) (
	input  wire  clk,
	input  wire  rst_b,
	input  wire  pll_enable,
	input  wire  vco_cal_busy,
	output logic pll_lock_detect
);
	int   wait_q;  // Settling cycles after calibration
	logic tuned_q; // Calibration has run since power-up

	// Reference held in range, lock follows a settle time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wait_q <= 0;
			tuned_q <= 1'b0;
			pll_lock_detect <= 1'b0;
		end else if (!pll_enable || vco_cal_busy) begin
			wait_q <= 0;
			tuned_q <= vco_cal_busy;
			pll_lock_detect <= 1'b0;
		end else if (tuned_q && wait_q < LOCK_DELAY) begin
			wait_q <= wait_q + 1;
		end else begin
			pll_lock_detect <= tuned_q;
		end
	end
endmodule

// ==== test/converter_clock_pll_control_tb.sv ====
`timescale 1ns/1ps
module converter_clock_pll_control_tb;
	logic        clk, rst_b, reg_wr, reg_rd, sample_valid, rd_d, sv_d;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, d;
	logic [5:0]  feedback_ratio;
	logic [15:0] code;
	logic [16:0] n;
	logic [3:0]  top;
	logic [7:0]  rd_q[$];  // Expected read data
	logic [16:0] smp_q[$]; // Expected samples with shuffle flag
	int          i, s, w, shuf_n, bad_count, total_checks;
	wire [7:0]   reg_rdata_q, full_scale_current_code;
	wire [2:0]   predivider_ratio, post_divider_ratio, clock_output_ratio;
	wire [8:0]   vco_multiplier;
	wire [15:0]  pos, neg;
	wire [14:0]  sel;
	wire         pll_enable, dcc, nvalid, vco_cal_start_q, busy, pll_locked, lock_det;
	wire         tick, from_pll;

	converter_clock_pll_control #(.CAL_CYCLES(16'h0004)) dut_u (
		.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .feedback_ratio(feedback_ratio),
		.pll_lock_detect(lock_det), .converter_sample_code(code), .sample_valid(sample_valid),
		.pll_enable(pll_enable), .sample_clock_from_pll(from_pll), .duty_cycle_correction_en(dcc),
		.predivider_ratio(predivider_ratio), .post_divider_ratio(post_divider_ratio),
		.clock_output_ratio(clock_output_ratio), .vco_multiplier(vco_multiplier),
		.feedback_ratio_valid(nvalid), .full_scale_current_code(full_scale_current_code),
		.vco_cal_start_q(vco_cal_start_q), .vco_cal_busy(busy), .pll_locked(pll_locked),
		.clock_output_tick(tick), .positive_branch_code_q(pos), .negative_branch_code_q(neg),
		.msb_source_select(sel));
	lock_detect_model lock_u (.clk(clk), .rst_b(rst_b), .pll_enable(pll_enable),
		.vco_cal_busy(busy), .pll_lock_detect(lock_det));

	always #10 clk = ~clk;

	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task end_sim;
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		rd_q.push_back(e);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
	endtask
	// One bounded wait step
	task step;
		w++;
		if (w > 50) begin
			bad_count++;
			$display("BAD wait exp done got hang");
			end_sim;
		end else begin
			@(negedge clk);
		end
	endtask

	// Note strobes at the taking edge
	always @(posedge clk) begin
		rd_d <= reg_rd;
		sv_d <= sample_valid;
	end
	// Compare results against the oldest note
	always @(negedge clk) begin
		if (rd_d)
			chk("rdata", {8'h00, rd_q.pop_front()}, {8'h00, reg_rdata_q});
		if (sv_d) begin
			n = smp_q.pop_front();
			top = n[15:12] ^ 4'h8;
			chk("pos", n[15:0] ^ 16'h8000, pos);
			chk("neg", ~(n[15:0] ^ 16'h8000), neg);
			chk("ones", {12'h000, top}, 16'($countones(sel)));
			if (!n[16])
				chk("therm", (16'h0001 << top) - 16'h0001, {1'b0, sel});
			else if ({1'b0, sel} !== (16'h0001 << top) - 16'h0001)
				shuf_n++;
		end
	end

	// Main sequence
	initial begin
		{clk, rst_b, reg_wr, reg_rd, sample_valid} = 5'h00;
		{reg_addr, reg_wdata, feedback_ratio, code} = 42'h0;
		bad_count = 0;
		total_checks = 0;
		void'($urandom(32'h93B3));
		repeat (4) @(negedge clk);
		rst_b = 1'b1;
		chk("pll_en", 16'h0000, {15'h0, pll_enable});
		chk("dcc", 16'h0001, {15'h0, dcc});
		chk("from_pll", 16'h0000, {15'h0, from_pll});
		rd(12'h05A, 8'h28);
		rd(12'h095, 8'h01);
		rd(12'h123, 8'h00);
		for (i = 0; i < 4; i++) begin
			wr(12'h793, 8'(i));
			wr(12'h094, 8'(i));
			wr(12'h799, 8'(i << 6));
			chk("pre", 16'(i + 1), {13'h0, predivider_ratio});
			chk("post", 16'(i + 1), {13'h0, post_divider_ratio});
			chk("clko", 16'(i + 1), {13'h0, clock_output_ratio});
			w = 0;
			while (tick !== 1'b1) step;
			w = 0;
			step;
			while (tick !== 1'b1) step;
			chk("tick", 16'(i + 1), 16'(w));
			rd(12'h799, 8'(i << 6));
		end
		repeat (10) begin
			feedback_ratio = 6'($urandom_range(63, 0));
			@(negedge clk);
			chk("mult", {7'h0, feedback_ratio, 3'h0}, {7'h0, vco_multiplier});
			chk("nvalid", 16'(feedback_ratio >= 2 && feedback_ratio <= 50), {15'h0, nvalid});
		end
		d = 8'($urandom);
		wr(12'h05A, d);
		chk("fsc", {8'h00, d}, {8'h00, full_scale_current_code});
		rd(12'h05A, d);
		wr(12'h095, 8'h00);
		chk("pll_en", 16'h0001, {15'h0, pll_enable});
		chk("from_pll", 16'h0001, {15'h0, from_pll});
		chk("dcc", 16'h0000, {15'h0, dcc});
		wr(12'h792, 8'h02);
		chk("busy", 16'h0000, {15'h0, busy});
		wr(12'h792, 8'h00);
		w = 0;
		while (busy !== 1'b1) step;
		while (busy !== 1'b0) step;
		while (pll_locked !== 1'b1) step;
		rd(12'h7B5, 8'h01);
		wr(12'h095, 8'h01);
		wr(12'h7B5, 8'hFF);
		rd(12'h7B5, 8'h00);
		for (s = 0; s < 2; s++) begin
			wr(12'h151, s ? 8'h10 : 8'h00);
			sample_valid = 1'b1;
			for (i = 0; i < 12; i++) begin
				code = i == 0 ? 16'h0000 : i == 1 ? 16'h7FFF : i == 2 ? 16'h8000 : 16'($urandom);
				smp_q.push_back({s[0], code});
				@(negedge clk);
			end
			sample_valid = 1'b0;
			@(negedge clk);
		end
		repeat (2) @(negedge clk);
		chk("shuffled", 16'h0001, 16'(shuf_n != 0));
		end_sim;
	end
endmodule
